/* core/wdt_ops_pkg.sv */
/*
 * shared constants for the watchdog clear and memory invert decoder.
 * assumes a 14-bit instruction word presented one per execute cycle.
 */
package wdt_ops_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 6;
	localparam int OP_W = 4;
	// operation select codes driven by the core's main decoder
	localparam logic [OP_W-1:0] OP_NONE = 4'h0;
	localparam logic [OP_W-1:0] OP_SINGLE_CLEAR = 4'h1;
	localparam logic [OP_W-1:0] OP_FIRST_PRECLEAR = 4'h2;
	localparam logic [OP_W-1:0] OP_SECOND_PRECLEAR = 4'h3;
	localparam logic [OP_W-1:0] OP_INVERT_MEM = 4'h4;
	localparam logic [DATA_W-1:0] WDT_CLEAR_VALUE = 8'h00;
	localparam logic PAIR_RESET = 1'b0;
	localparam logic FLAG_RESET = 1'b0;
	typedef enum logic [1:0] {
		PAIR_IDLE = 2'b00,
		PAIR_GOT_FIRST = 2'b01,
		PAIR_GOT_SECOND = 2'b10
	} pair_state_t;
endpackage

/* core/mem_invert.sv */
/*
 * combinational invert of one data memory byte and its zero result.
 * assumes the byte read from memory is stable during the execute cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module mem_invert
	import wdt_ops_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	// operand
	input wire logic [WIDTH-1:0] din,
	// result
	output logic [WIDTH-1:0] dout,
	output logic is_zero
);
	always_comb begin
		dout = ~din;
		is_zero = (dout == '0);
	end
endmodule // mem_invert
`default_nettype wire

/* core/wdt_ops.sv */
/*
 * execute stage for watchdog clear, paired preclear and memory invert.
 * assumes the core decoder presents one op per cycle with op_valid, and
 * memory/flag writes are applied by the core on the strobes given here.
 */
// Functional notes
// - single clear zeroes watchdog and clears timeout and power-down flags
// - preclear pair completed clears watchdog and both flags
// - lone first preclear only records that first half ran
// - lone second preclear only records itself; pair completes any order
// - half a pair leaves timeout and power-down flags unchanged
// - invert op writes back bitwise complement of addressed byte
// - invert op sets zero flag from written result
`timescale 1ns/100ps
`default_nettype none
module wdt_ops
	import wdt_ops_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int AW = ADDR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// decoded operation
	input wire logic op_valid,
	input wire logic [OP_W-1:0] op_sel,
	input wire logic [AW-1:0] op_addr,
	input wire logic [WIDTH-1:0] mem_rdata,
	// flags in from core
	input wire logic flag_zero_in,
	// status flag set requests from the watchdog and halt logic
	input wire logic set_timeout,
	input wire logic set_power_down,
	// memory write back
	output logic mem_we,
	output logic [AW-1:0] mem_waddr,
	output logic [WIDTH-1:0] mem_wdata,
	// watchdog control
	output logic wdt_clear,
	output logic [WIDTH-1:0] wdt_clear_value,
	// status flags
	output logic timeout_flag,
	output logic power_down_flag,
	output logic flag_zero_we,
	output logic flag_zero,
	output logic [1:0] pair_state
);
	// decoded strobes; an unknown or idle code raises none of them
	logic do_single, do_first, do_second, do_invert;
	// the half just executed meets its recorded partner
	logic pair_done;

	pair_state_t pair_r, pair_nxt;
	logic to_r, to_nxt, pd_r, pd_nxt;
	logic clr_r, clr_nxt;
	logic we_r, we_nxt, zwe_r, zwe_nxt, z_r, z_nxt;
	logic [AW-1:0] wa_r, wa_nxt;
	logic [WIDTH-1:0] wd_r, wd_nxt, inv;
	logic inv_zero;

	mem_invert #(.WIDTH(WIDTH)) u_inv (
		.din(mem_rdata),
		.dout(inv),
		.is_zero(inv_zero)
	);

	// op decode
	always_comb begin
		do_single = 1'b0;
		do_first = 1'b0;
		do_second = 1'b0;
		do_invert = 1'b0;
		if (op_valid) begin
			unique case (op_sel)
				OP_SINGLE_CLEAR: begin
					do_single = 1'b1;
				end
				OP_FIRST_PRECLEAR: begin
					do_first = 1'b1;
				end
				OP_SECOND_PRECLEAR: begin
					do_second = 1'b1;
				end
				OP_INVERT_MEM: begin
					do_invert = 1'b1;
				end
				default: begin
					// idle and unknown codes leave every state alone
					do_invert = 1'b0;
				end
			endcase
		end
	end

	// preclear pair tracker: only the other half completes the pair
	always_comb begin
		pair_nxt = pair_r;
		pair_done = 1'b0;
		unique case (pair_r)
			PAIR_IDLE: begin
				if (do_first) begin
					pair_nxt = PAIR_GOT_FIRST;
				end else if (do_second) begin
					pair_nxt = PAIR_GOT_SECOND;
				end
			end
			PAIR_GOT_FIRST: begin
				// a repeat of the first half keeps waiting for its partner
				if (do_second) begin
					pair_done = 1'b1;
					pair_nxt = PAIR_IDLE;
				end
			end
			PAIR_GOT_SECOND: begin
				if (do_first) begin
					pair_done = 1'b1;
					pair_nxt = PAIR_IDLE;
				end
			end
			default: begin
				// the unused code falls back to idle
				pair_nxt = PAIR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pair_r <= PAIR_IDLE;
		end else begin
			pair_r <= pair_nxt;
		end
	end

	// watchdog clear strobe, high for the one cycle after the taking edge
	always_comb begin
		clr_nxt = 1'b0;
		if (do_single || pair_done) begin
			clr_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clr_r <= 1'b0;
		end else begin
			clr_r <= clr_nxt;
		end
	end

	// timeout and power-down status flags
	always_comb begin
		// a lone preclear half falls through and keeps both flags
		to_nxt = to_r;
		pd_nxt = pd_r;
		if (do_single || pair_done) begin
			to_nxt = FLAG_RESET;
			pd_nxt = FLAG_RESET;
		end
		// a set in the same cycle as a clear wins, so no event is lost
		if (set_timeout) begin
			to_nxt = 1'b1;
		end
		if (set_power_down) begin
			pd_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			to_r <= FLAG_RESET;
			pd_r <= FLAG_RESET;
		end else begin
			to_r <= to_nxt;
			pd_r <= pd_nxt;
		end
	end

	// memory write back and zero flag update of the invert op
	always_comb begin
		we_nxt = do_invert;
		// watchdog ops never raise the zero flag strobe
		zwe_nxt = do_invert;
		wa_nxt = wa_r;
		wd_nxt = wd_r;
		// outside a write the core's own flag is echoed back unchanged
		z_nxt = flag_zero_in;
		if (do_invert) begin
			wa_nxt = op_addr;
			wd_nxt = inv;
			z_nxt = inv_zero;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			we_r <= 1'b0;
			wa_r <= '0;
			wd_r <= '0;
			zwe_r <= 1'b0;
			z_r <= 1'b0;
		end else begin
			we_r <= we_nxt;
			wa_r <= wa_nxt;
			wd_r <= wd_nxt;
			zwe_r <= zwe_nxt;
			z_r <= z_nxt;
		end
	end

	// pulses last one cycle; flags and pair state hold until changed
	assign mem_we = we_r;
	assign mem_waddr = wa_r;
	assign mem_wdata = wd_r;
	assign wdt_clear = clr_r;
	// the clear value is fixed, so it is sized to the port width here
	assign wdt_clear_value = WIDTH'(WDT_CLEAR_VALUE);
	assign timeout_flag = to_r;
	assign power_down_flag = pd_r;
	assign flag_zero_we = zwe_r;
	assign flag_zero = z_r;
	assign pair_state = pair_r;
endmodule // wdt_ops
`default_nettype wire

/* sim/wdt_ops_monitor.sv */
/* port assertions for wdt_ops.
 * assumes the core package is compiled first; bound to every instance. */
`timescale 1ns/100ps
`default_nettype none
module wdt_ops_monitor
	import wdt_ops_pkg::*;
(
	input wire logic clk, rst, op_valid, mem_we, wdt_clear, timeout_flag,
	input wire logic power_down_flag, flag_zero_we, flag_zero,
	input wire logic set_timeout, set_power_down,
	input wire logic [OP_W-1:0] op_sel,
	input wire logic [5:0] op_addr, mem_waddr,
	input wire logic [7:0] mem_rdata, mem_wdata, wdt_clear_value,
	input wire logic [1:0] pair_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic s1 = op_valid && op_sel == OP_SINGLE_CLEAR;
	wire logic p1 = op_valid && op_sel == OP_FIRST_PRECLEAR;
	wire logic p2 = op_valid && op_sel == OP_SECOND_PRECLEAR;
	wire logic inv = op_valid && op_sel == OP_INVERT_MEM;
	// a flag set request in the same cycle wins over a clear
	wire logic no_set = !set_timeout && !set_power_down;
	a_single_clear: assert property (s1 && no_set |=> wdt_clear &&
		wdt_clear_value == WDT_CLEAR_VALUE && !timeout_flag &&
		!power_down_flag) else $error("single clear missed");
	a_pair_reverse: assert property (p1 && no_set &&
		pair_state == PAIR_GOT_SECOND |=> wdt_clear &&
		pair_state == PAIR_IDLE && !timeout_flag && !power_down_flag)
		else $error("reverse pair missed");
	a_pair_done: assert property (p2 && pair_state == PAIR_GOT_FIRST
		|=> wdt_clear && pair_state == PAIR_IDLE) else $error("pair missed");
	a_first_half: assert property (p1 && pair_state != PAIR_GOT_SECOND
		|=> !wdt_clear && pair_state == PAIR_GOT_FIRST) else $error("first");
	a_second_half: assert property (p2 && pair_state != PAIR_GOT_FIRST
		|=> !wdt_clear && pair_state == PAIR_GOT_SECOND) else $error("second");
	a_half_flags: assert property (no_set && (p1 &&
		pair_state != PAIR_GOT_SECOND || p2 && pair_state != PAIR_GOT_FIRST)
		|=> $stable(timeout_flag) && $stable(power_down_flag))
		else $error("half pair moved flags");
	a_invert_data: assert property (inv |=> mem_we &&
		mem_wdata == ~$past(mem_rdata) && mem_waddr == $past(op_addr))
		else $error("invert data");
	a_invert_zero: assert property (inv |=> flag_zero_we &&
		flag_zero == ($past(mem_rdata) == 8'hFF)) else $error("invert zero");
	a_wdt_no_flags: assert property (s1 || p1 || p2
		|=> !flag_zero_we) else $error("watchdog op wrote zero flag");
	c_clear: cover property (wdt_clear);
	c_zero: cover property (mem_we && flag_zero);
	c_second: cover property (pair_state == PAIR_GOT_SECOND);
endmodule // wdt_ops_monitor
bind wdt_ops wdt_ops_monitor mon_u (.*);
`default_nettype wire

/* sim/wdt_ops_tb.sv */
/* self-checking bench for wdt_ops.
 * assumes no far-side model: the bench drives every port itself. */
`timescale 1ns/100ps
`default_nettype none
module wdt_ops_tb
	import wdt_ops_pkg::*;
;
	logic clk = 0, rst = 1, op_valid = 0, flag_zero_in = 0;
	logic set_timeout = 0, set_power_down = 0;
	logic [OP_W-1:0] op_sel = OP_NONE;
	logic [5:0] op_addr = 6'h00, mem_waddr;
	logic [7:0] mem_rdata = 8'h00, mem_wdata, wdt_clear_value;
	logic mem_we, wdt_clear, timeout_flag, power_down_flag;
	logic flag_zero_we, flag_zero;
	logic [1:0] pair_state;
	int error_cnt = 0, checked = 0;
	wdt_ops dut_u (.*);
	initial begin
		forever #5 clk = ~clk;
	end
	// one op per call; outputs of that op are settled when it returns
	task op(input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		#1 op_valid = 1;
		op_sel = s;
		op_addr = d[5:0];
		mem_rdata = d;
		@(posedge clk);
		#1 op_valid = 0;
	endtask
	task chk(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one-cycle set request on both status flags, no op in that cycle
	task raise_flags;
		@(posedge clk);
		#1 set_timeout = 1;
		set_power_down = 1;
		@(posedge clk);
		#1 set_timeout = 0;
		set_power_down = 0;
		chk({timeout_flag, power_down_flag}, 2'h3);
	endtask
	task t_single;
		raise_flags;
		op(OP_SINGLE_CLEAR, 8'h00);
		chk({wdt_clear, wdt_clear_value}, 16'h0100);
		chk({timeout_flag, power_down_flag}, 2'h0);
		chk(flag_zero_we, 1'b0);
		$display("single clear done");
	endtask
	task t_pair;
		raise_flags;
		op(OP_FIRST_PRECLEAR, 8'h00);
		chk({wdt_clear, pair_state}, 3'h1);
		chk({timeout_flag, power_down_flag}, 2'h3);
		op(4'hF, 8'h00);
		chk({wdt_clear, mem_we, flag_zero_we, pair_state}, 5'h01);
		op(OP_INVERT_MEM, 8'h3C);
		chk(pair_state, 2'h1);
		op(OP_SECOND_PRECLEAR, 8'h00);
		chk({wdt_clear, pair_state}, 3'h4);
		chk({timeout_flag, power_down_flag}, 2'h0);
		raise_flags;
		op(OP_SECOND_PRECLEAR, 8'h00);
		op(OP_SECOND_PRECLEAR, 8'h00);
		chk({wdt_clear, pair_state}, 3'h2);
		chk({timeout_flag, power_down_flag}, 2'h3);
		op(OP_FIRST_PRECLEAR, 8'h00);
		chk({wdt_clear, pair_state}, 3'h4);
		chk({timeout_flag, power_down_flag}, 2'h0);
		$display("preclear pair done");
	endtask
	task t_invert;
		logic [7:0] d[3] = '{8'hFF, 8'h00, 8'hA5};
		foreach (d[i]) begin
			op(OP_INVERT_MEM, d[i]);
			chk({mem_we, mem_waddr}, {1'b1, d[i][5:0]});
			chk(mem_wdata, {~d[i]});
			chk({flag_zero_we, flag_zero}, {1'b1, d[i] == 8'hFF});
		end
		$display("invert done");
	endtask
	// reset in mid-run must drop flags, strobes and a half-done pair
	task t_reset;
		raise_flags;
		op(OP_FIRST_PRECLEAR, 8'h00);
		op(OP_INVERT_MEM, 8'h2A);
		@(posedge clk);
		#1 rst = 1;
		#1 chk({mem_we, mem_waddr, mem_wdata}, 15'h0000);
		chk({wdt_clear, timeout_flag, power_down_flag, flag_zero_we,
			flag_zero, pair_state}, 7'h00);
		repeat (3) @(posedge clk);
		#1 rst = 0;
		op(OP_SECOND_PRECLEAR, 8'h00);
		chk({wdt_clear, pair_state}, 3'h2);
		$display("reset done");
	endtask
	task print_verdict;
		$display("checked %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// all tests take under 100 cycles; this is far beyond that
	initial begin
		#5000;
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 0;
		t_single;
		t_pair;
		t_invert;
		t_reset;
		print_verdict;
	end
endmodule // wdt_ops_tb
`default_nettype wire
